// ===== verilog/cmfs_defs.svh
// constants for the cube map face selection stage
`ifndef CMFS_DEFS_SVH
`define CMFS_DEFS_SVH
`define CMFS_DIR_W       16
`define CMFS_EXT_W       18
`define CMFS_REM_W       19
`define CMFS_COORD_W     16
`define CMFS_COORD_HALF  16'h4000
`define CMFS_COORD_ONE   16'h8000
`define CMFS_DIV_STEPS   5'h10
`define CMFS_IDX_W       12
`define CMFS_TEXEL_W     32
`define CMFS_CHAN_W      8
`define CMFS_CHANNELS    4
`define CMFS_RECIP3      16'h5556
`define CMFS_RECIP3_SHR  16
`endif

// ===== verilog/cmfs_pkg.sv
// types and shared face decoding for the cube map face selection stage
`default_nettype none
package cmfs_pkg;
`include "cmfs_defs.svh"

	// face index order is fixed: 0..5
	typedef enum logic [2:0] {
		face_pos_x, face_neg_x, face_pos_y, face_neg_y, face_pos_z, face_neg_z
	} cmfs_face_type;

	typedef enum logic [1:0] {
		edge_clamp_wrap, border_clamp_wrap, repeat_wrap, mirror_wrap
	} cmfs_wrap_type;

	typedef enum {st_idle, st_divide, st_hold} cmfs_state_type;

	typedef logic signed [`CMFS_EXT_W-1:0] cmfs_vec_type;

	// ----------------------------------------
	// major axis pick
	// ----------------------------------------
	// ties go x before y before z, depends only on the vector
	function automatic cmfs_face_type cmfs_major(input cmfs_vec_type x, input cmfs_vec_type y,
		input cmfs_vec_type z);
		cmfs_vec_type ax;
		cmfs_vec_type ay;
		cmfs_vec_type az;
		ax = x[`CMFS_EXT_W-1] ? -x : x;
		ay = y[`CMFS_EXT_W-1] ? -y : y;
		az = z[`CMFS_EXT_W-1] ? -z : z;
		if (ax >= ay && ax >= az) begin
			return x[`CMFS_EXT_W-1] ? face_neg_x : face_pos_x;
		end else if (ay >= az) begin
			return y[`CMFS_EXT_W-1] ? face_neg_y : face_pos_y;
		end
		return z[`CMFS_EXT_W-1] ? face_neg_z : face_pos_z;
	endfunction

	// ----------------------------------------
	// face-local coordinates
	// ----------------------------------------
	function automatic void cmfs_project(input cmfs_face_type f, input cmfs_vec_type x,
		input cmfs_vec_type y, input cmfs_vec_type z, output cmfs_vec_type sc,
		output cmfs_vec_type tc, output cmfs_vec_type ma);
		case (f)
			face_pos_x: begin sc = -z; tc = -y; ma = x; end
			face_neg_x: begin sc = z;  tc = -y; ma = x; end
			face_pos_y: begin sc = x;  tc = z;  ma = y; end
			face_neg_y: begin sc = x;  tc = -z; ma = y; end
			face_pos_z: begin sc = x;  tc = -y; ma = z; end
			default:    begin sc = -x; tc = -y; ma = z; end
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== verilog/cmfs_frac_div.sv
// restoring divider giving num/den as a 1.15 fraction, num not above den
`timescale 1ns/1ps
`default_nettype none
`include "cmfs_defs.svh"
module cmfs_frac_div (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     nrst,
	// operands: num taken on start, den read every cycle of the division
	input  wire logic                     start,
	input  wire logic [`CMFS_EXT_W-1:0]   num,
	input  wire logic [`CMFS_EXT_W-1:0]   den,
	// result
	output logic                          busy,
	output logic [`CMFS_COORD_W-1:0]      quot
);
	typedef struct packed {
		logic [`CMFS_REM_W-1:0]   rem;
		logic [`CMFS_COORD_W-1:0] q;
		logic [4:0]               cnt;
		logic                     busy;
	} cmfs_div_state_type;

	cmfs_div_state_type r;
	cmfs_div_state_type next_r;
	logic [`CMFS_REM_W-1:0] den_w;
	logic [`CMFS_REM_W-1:0] rem_after;
	logic                   ge;

	// one quotient bit per cycle; area traded for 16 cycles of latency
	always_comb begin
		next_r = r;
		den_w = {1'b0, den};
		ge = r.rem >= den_w;
		rem_after = ge ? r.rem - den_w : r.rem;
		if (start) begin
			next_r.rem = {1'b0, num};
			next_r.q = '0;
			next_r.cnt = `CMFS_DIV_STEPS;
			next_r.busy = 1'b1;
		end else if (r.busy) begin
			next_r.rem = {rem_after[`CMFS_REM_W-2:0], 1'b0};
			next_r.q = {r.q[`CMFS_COORD_W-2:0], ge};
			next_r.cnt = r.cnt - 5'h01;
			next_r.busy = r.cnt != 5'h01;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign busy = r.busy;
	assign quot = r.q;

	property p_div_range;
		@(posedge clk) disable iff (!nrst) $fell(r.busy) |-> r.q <= `CMFS_COORD_ONE;
	endproperty
	a_div_range: assert property (p_div_range) else $error("quotient above one");
endmodule
`default_nettype wire

// ===== verilog/cmfs_tap_remap.sv
// seamless cube edge handling of one filter tap index pair
`timescale 1ns/1ps
`default_nettype none
`include "cmfs_defs.svh"
module cmfs_tap_remap (
	// tap in
	input  wire logic [2:0]                    face,
	input  wire logic signed [`CMFS_IDX_W-1:0] i,
	input  wire logic signed [`CMFS_IDX_W-1:0] j,
	input  wire logic [`CMFS_IDX_W-1:0]        size,
	input  wire logic                          bilinear,
	input  wire logic                          cube,
	input  wire logic [1:0]                    wrap_s,
	input  wire logic [1:0]                    wrap_t,
	// tap out
	output logic [2:0]                         out_face,
	output logic signed [`CMFS_IDX_W-1:0]      out_i,
	output logic signed [`CMFS_IDX_W-1:0]      out_j,
	output logic                               corner,
	output logic                               border
);
	typedef logic signed [`CMFS_IDX_W-1:0] cmfs_idx_type;

	// clamp modes only; repeat and mirror pass through to the fetch stage
	function automatic cmfs_idx_type wrap_idx(input cmfs_idx_type c, input cmfs_idx_type n,
		input cmfs_pkg::cmfs_wrap_type m);
		cmfs_idx_type lo;
		cmfs_idx_type hi;
		lo = (m == cmfs_pkg::edge_clamp_wrap) ? '0 : '1;
		hi = (m == cmfs_pkg::edge_clamp_wrap) ? n - 1'b1 : n;
		if (m != cmfs_pkg::edge_clamp_wrap && m != cmfs_pkg::border_clamp_wrap) begin
			return c;
		end
		return (c < lo) ? lo : (c > hi) ? hi : c;
	endfunction

	// centred coordinate back to an index on the new face
	function automatic cmfs_idx_type to_index(input cmfs_pkg::cmfs_vec_type c,
		input cmfs_pkg::cmfs_vec_type n);
		cmfs_pkg::cmfs_vec_type v;
		// keep the sum signed so a coordinate of -n clamps to index 0, not n-1
		v = (c + n - cmfs_pkg::cmfs_vec_type'(1)) >>> 1;
		v = (v < 0) ? '0 : (v >= n) ? n - cmfs_pkg::cmfs_vec_type'(1) : v;
		return v[`CMFS_IDX_W-1:0];
	endfunction

	cmfs_pkg::cmfs_wrap_type mode_s;
	cmfs_pkg::cmfs_wrap_type mode_t;
	cmfs_pkg::cmfs_face_type nf;
	cmfs_pkg::cmfs_vec_type  cs, ct, n, x, y, z, sc, tc, ma;
	cmfs_idx_type            ci, cj, nsz;
	logic                    out_s, out_t;

	// wrap, detect border taps, then hop to the neighbouring face
	always_comb begin
		nsz = cmfs_idx_type'(size);
		mode_s = cube ? (bilinear ? cmfs_pkg::border_clamp_wrap : cmfs_pkg::edge_clamp_wrap)
			: cmfs_pkg::cmfs_wrap_type'(wrap_s);
		mode_t = cube ? (bilinear ? cmfs_pkg::border_clamp_wrap : cmfs_pkg::edge_clamp_wrap)
			: cmfs_pkg::cmfs_wrap_type'(wrap_t);
		ci = wrap_idx(i, nsz, mode_s);
		cj = wrap_idx(j, nsz, mode_t);
		out_s = ci < 0 || ci >= nsz;
		out_t = cj < 0 || cj >= nsz;
		n = cmfs_pkg::cmfs_vec_type'({1'b0, size});
		cs = cmfs_pkg::cmfs_vec_type'($signed({ci, 1'b1})) - n;
		ct = cmfs_pkg::cmfs_vec_type'($signed({cj, 1'b1})) - n;
		// rebuild the direction of the texel centre on the old face
		case (cmfs_pkg::cmfs_face_type'(face))
			cmfs_pkg::face_pos_x: begin x = n;  y = -ct; z = -cs; end
			cmfs_pkg::face_neg_x: begin x = -n; y = -ct; z = cs;  end
			cmfs_pkg::face_pos_y: begin x = cs; y = n;   z = ct;  end
			cmfs_pkg::face_neg_y: begin x = cs; y = -n;  z = -ct; end
			cmfs_pkg::face_pos_z: begin x = cs; y = -ct; z = n;   end
			default:              begin x = -cs; y = -ct; z = -n; end
		endcase
		// overshoot component is n+1, so it wins the new major axis strictly
		nf = cmfs_pkg::cmfs_major(x, y, z);
		cmfs_pkg::cmfs_project(nf, x, y, z, sc, tc, ma);
		corner = cube && out_s && out_t;
		border = !cube && (out_s || out_t);
		if (cube && (out_s ^ out_t)) begin
			out_face = nf;
			out_i = to_index(sc, n);
			out_j = to_index(tc, n);
		end else begin
			out_face = face;
			out_i = ci;
			out_j = cj;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/cmfs_face_select.sv
// cube map face selection, face coordinate normalisation and seamless tap handling
//
// Overview of operation
// - with cube texturing on, the three coordinates are a direction from the cube centre.
// - the face is the one on the axis of the largest magnitude component, with its sign.
// - ties in magnitude are broken deterministically from the three components alone.
// - +x face takes s=-z, t=-y, major x; -x face takes s=z, t=-y, major x.
// - +y face takes s=x, t=z, major y; -y face takes s=x, t=-z, major y.
// - +z face takes s=x, t=-y, major z; -z face takes s=-x, t=-y, major z.
// - each output coordinate is half of (face component over absolute major, plus one).
// - on cube textures the programmed wrap modes are ignored in favour of seamless rules.
// - point sampling on a cube texture always clamps indices to the face edge.
// - bilinear sampling on a cube texture applies border clamping before face substitution.
// - a tap in the border on exactly one axis fetches from the adjacent face instead.
// - a tap in a cube corner is made as the mean of the three real samples.
// - the synthesised corner texel equals the common value when the three samples agree.
`timescale 1ns/1ps
`default_nettype none
`include "cmfs_defs.svh"
module cmfs_face_select (
	// clock and reset
	input  wire logic                          CORE_CLK,
	input  wire logic                          NRST,
	// mode
	input  wire logic                          CUBE_EN,
	// direction in
	input  wire logic                          IN_VALID,
	output logic                               IN_READY,
	input  wire logic signed [`CMFS_DIR_W-1:0] DIR_X,
	input  wire logic signed [`CMFS_DIR_W-1:0] DIR_Y,
	input  wire logic signed [`CMFS_DIR_W-1:0] DIR_Z,
	// face coordinates out
	output logic                               OUT_VALID,
	input  wire logic                          OUT_READY,
	output logic [2:0]                         OUT_FACE,
	output logic [`CMFS_COORD_W-1:0]           OUT_S,
	output logic [`CMFS_COORD_W-1:0]           OUT_T,
	// filter tap in
	input  wire logic                          TAP_VALID,
	input  wire logic [2:0]                    TAP_FACE,
	input  wire logic signed [`CMFS_IDX_W-1:0] TAP_I,
	input  wire logic signed [`CMFS_IDX_W-1:0] TAP_J,
	input  wire logic [`CMFS_IDX_W-1:0]        FACE_SIZE,
	input  wire logic                          TAP_BILINEAR,
	input  wire logic [1:0]                    WRAP_S,
	input  wire logic [1:0]                    WRAP_T,
	// filter tap out
	output logic                               TAP_OUT_VALID,
	output logic [2:0]                         TAP_OUT_FACE,
	output logic signed [`CMFS_IDX_W-1:0]      TAP_OUT_I,
	output logic signed [`CMFS_IDX_W-1:0]      TAP_OUT_J,
	output logic                               TAP_CORNER,
	output logic                               TAP_BORDER,
	// corner synthesis
	input  wire logic                          CORNER_VALID,
	input  wire logic [`CMFS_TEXEL_W-1:0]      CORNER_A,
	input  wire logic [`CMFS_TEXEL_W-1:0]      CORNER_B,
	input  wire logic [`CMFS_TEXEL_W-1:0]      CORNER_C,
	output logic                               CORNER_OUT_VALID,
	output logic [`CMFS_TEXEL_W-1:0]           CORNER_OUT
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		cmfs_pkg::cmfs_state_type          st;
		logic [2:0]                        face;
		logic [`CMFS_COORD_W-1:0]          s;
		logic [`CMFS_COORD_W-1:0]          t;
		logic                              tap_vld;
		logic [2:0]                        tap_face;
		logic signed [`CMFS_IDX_W-1:0]     tap_i;
		logic signed [`CMFS_IDX_W-1:0]     tap_j;
		logic                              tap_corner;
		logic                              tap_border;
		logic                              crn_vld;
		logic [`CMFS_TEXEL_W-1:0]          crn;
	} cmfs_top_state_type;

	cmfs_top_state_type      r;
	cmfs_top_state_type      next_r;
	cmfs_pkg::cmfs_vec_type  vx, vy, vz, sc, tc, ma, ama;
	cmfs_pkg::cmfs_face_type face_w;
	logic [`CMFS_EXT_W-1:0]  num_s, num_t, den;
	logic                    take, ma_zero, div_start;
	logic                    busy_s, busy_t;
	logic [`CMFS_COORD_W-1:0] quot_s, quot_t;
	logic [2:0]              rm_face;
	logic signed [`CMFS_IDX_W-1:0] rm_i, rm_j;
	logic                    rm_corner, rm_border;
	logic [`CMFS_TEXEL_W-1:0] mean_w;

	// ----------------------------------------
	// face pick and division operands
	// ----------------------------------------
	// operands go straight to the dividers so they start in the take cycle
	always_comb begin
		vx = cmfs_pkg::cmfs_vec_type'(DIR_X);
		vy = cmfs_pkg::cmfs_vec_type'(DIR_Y);
		vz = cmfs_pkg::cmfs_vec_type'(DIR_Z);
		face_w = cmfs_pkg::cmfs_major(vx, vy, vz);
		cmfs_pkg::cmfs_project(face_w, vx, vy, vz, sc, tc, ma);
		ama = ma[`CMFS_EXT_W-1] ? -ma : ma;
		ma_zero = ama == '0;
		num_s = sc + ama;
		num_t = tc + ama;
		den = {ama[`CMFS_EXT_W-2:0], 1'b0};
	end

	assign IN_READY = r.st == cmfs_pkg::st_idle;
	assign take = IN_READY && IN_VALID;
	assign div_start = take && CUBE_EN && !ma_zero;

	// s and t are divided side by side
	cmfs_frac_div u_div_s (
		.clk   (CORE_CLK),
		.nrst  (NRST),
		.start (div_start),
		.num   (num_s),
		.den   (den),
		.busy  (busy_s),
		.quot  (quot_s)
	);

	cmfs_frac_div u_div_t (
		.clk   (CORE_CLK),
		.nrst  (NRST),
		.start (div_start),
		.num   (num_t),
		.den   (den),
		.busy  (busy_t),
		.quot  (quot_t)
	);

	// ----------------------------------------
	// tap remap and corner mean
	// ----------------------------------------
	cmfs_tap_remap u_remap (
		.face     (TAP_FACE),
		.i        (TAP_I),
		.j        (TAP_J),
		.size     (FACE_SIZE),
		.bilinear (TAP_BILINEAR),
		.cube     (CUBE_EN),
		.wrap_s   (WRAP_S),
		.wrap_t   (WRAP_T),
		.out_face (rm_face),
		.out_i    (rm_i),
		.out_j    (rm_j),
		.corner   (rm_corner),
		.border   (rm_border)
	);

	// multiply by 1/3; exact for equal inputs since 3v*0x5556>>16 is v below 32768
	function automatic logic [`CMFS_CHAN_W-1:0] mean3(input logic [`CMFS_CHAN_W-1:0] a,
		input logic [`CMFS_CHAN_W-1:0] b, input logic [`CMFS_CHAN_W-1:0] c);
		logic [`CMFS_CHAN_W+1:0] sum;
		logic [`CMFS_CHAN_W+25:0] prod;
		sum = {2'b00, a} + {2'b00, b} + {2'b00, c};
		prod = sum * `CMFS_RECIP3;
		return prod[`CMFS_RECIP3_SHR +: `CMFS_CHAN_W];
	endfunction

	// per channel average of the three real corner samples
	for (genvar g = 0; g < `CMFS_CHANNELS; g++) begin : g_chan
		assign mean_w[g*`CMFS_CHAN_W +: `CMFS_CHAN_W] = mean3(CORNER_A[g*`CMFS_CHAN_W +: `CMFS_CHAN_W],
			CORNER_B[g*`CMFS_CHAN_W +: `CMFS_CHAN_W], CORNER_C[g*`CMFS_CHAN_W +: `CMFS_CHAN_W]);
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_r = r;
		case (r.st)
			cmfs_pkg::st_idle: begin
				if (take) begin
					next_r.face = CUBE_EN ? face_w : 3'h0;
					if (!CUBE_EN) begin
						// planar coordinates pass untouched
						next_r.s = DIR_X;
						next_r.t = DIR_Y;
						next_r.st = cmfs_pkg::st_hold;
					end else if (ma_zero) begin
						// zero vector has no direction: centre of the face
						next_r.s = `CMFS_COORD_HALF;
						next_r.t = `CMFS_COORD_HALF;
						next_r.st = cmfs_pkg::st_hold;
					end else begin
						next_r.st = cmfs_pkg::st_divide;
					end
				end
			end
			cmfs_pkg::st_divide: begin
				if (!busy_s && !busy_t) begin
					next_r.s = quot_s;
					next_r.t = quot_t;
					next_r.st = cmfs_pkg::st_hold;
				end
			end
			cmfs_pkg::st_hold: begin
				if (OUT_READY) begin
					next_r.st = cmfs_pkg::st_idle;
				end
			end
			default: next_r.st = cmfs_pkg::st_idle;
		endcase
		// tap and corner paths are one register stage, no back-pressure
		next_r.tap_vld = TAP_VALID;
		if (TAP_VALID) begin
			next_r.tap_face = rm_face;
			next_r.tap_i = rm_i;
			next_r.tap_j = rm_j;
			next_r.tap_corner = rm_corner;
			next_r.tap_border = rm_border;
		end
		next_r.crn_vld = CORNER_VALID;
		if (CORNER_VALID) begin
			next_r.crn = mean_w;
		end
	end

	// state register
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign OUT_VALID = r.st == cmfs_pkg::st_hold;
	assign OUT_FACE = r.face;
	assign OUT_S = r.s;
	assign OUT_T = r.t;
	assign TAP_OUT_VALID = r.tap_vld;
	assign TAP_OUT_FACE = r.tap_face;
	assign TAP_OUT_I = r.tap_i;
	assign TAP_OUT_J = r.tap_j;
	assign TAP_CORNER = r.tap_corner;
	assign TAP_BORDER = r.tap_border;
	assign CORNER_OUT_VALID = r.crn_vld;
	assign CORNER_OUT = r.crn;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_planar;
		@(posedge CORE_CLK) disable iff (!NRST)
		take && !CUBE_EN |=> OUT_VALID && OUT_S == $past(DIR_X) && OUT_FACE == 3'h0;
	endproperty
	a_planar: assert property (p_planar) else $error("planar pass wrong");

	property p_major;
		@(posedge CORE_CLK) disable iff (!NRST)
		take && CUBE_EN && DIR_Z < 0 && -vz > vx && -vz > -vx && -vz > vy && -vz > -vy
		|=> r.face == 3'h5;
	endproperty
	a_major: assert property (p_major) else $error("negative z not chosen");

	property p_tie;
		@(posedge CORE_CLK) disable iff (!NRST)
		take && CUBE_EN && DIR_X > 0 && vx == vy && vx == vz |=> r.face == 3'h0;
	endproperty
	a_tie: assert property (p_tie) else $error("tie not resolved to x");

	property p_pos_y_centre;
		@(posedge CORE_CLK) disable iff (!NRST)
		take && CUBE_EN && DIR_Y > 0 && DIR_X == 0 && DIR_Z == 0
		|-> ##18 OUT_VALID && OUT_FACE == 3'h2 && OUT_S == `CMFS_COORD_HALF && OUT_T == `CMFS_COORD_HALF;
	endproperty
	a_pos_y_centre: assert property (p_pos_y_centre) else $error("+y centre wrong");

	property p_neg_x_edge;
		@(posedge CORE_CLK) disable iff (!NRST)
		take && CUBE_EN && DIR_X == -16'sh4000 && DIR_Y == 0 && DIR_Z == 16'sh4000
		|-> ##18 OUT_FACE == 3'h1 && OUT_S == `CMFS_COORD_ONE && OUT_T == `CMFS_COORD_HALF;
	endproperty
	a_neg_x_edge: assert property (p_neg_x_edge) else $error("-x coordinates wrong");

	property p_latency;
		@(posedge CORE_CLK) disable iff (!NRST)
		div_start |-> !OUT_VALID [*8] ##11 OUT_VALID;
	endproperty
	a_latency: assert property (p_latency) else $error("division latency wrong");

	property p_hold;
		@(posedge CORE_CLK) disable iff (!NRST)
		OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_S) && $stable(OUT_T) && $stable(OUT_FACE);
	endproperty
	a_hold: assert property (p_hold) else $error("output moved while held");

	property p_nearest;
		@(posedge CORE_CLK) disable iff (!NRST)
		TAP_VALID && CUBE_EN && !TAP_BILINEAR && FACE_SIZE != 0
		|=> TAP_OUT_I >= 0 && TAP_OUT_J >= 0 && TAP_OUT_FACE == $past(TAP_FACE) && !TAP_CORNER;
	endproperty
	a_nearest: assert property (p_nearest) else $error("nearest tap left the face");

	property p_no_border;
		@(posedge CORE_CLK) disable iff (!NRST)
		TAP_VALID && CUBE_EN |=> !TAP_BORDER;
	endproperty
	a_no_border: assert property (p_no_border) else $error("cube tap used border colour");

	property p_far_tap;
		@(posedge CORE_CLK) disable iff (!NRST)
		TAP_VALID && CUBE_EN && TAP_BILINEAR && TAP_I < -1 && TAP_J >= 0 && TAP_J < FACE_SIZE
		|=> TAP_OUT_FACE != $past(TAP_FACE) && !TAP_CORNER;
	endproperty
	a_far_tap: assert property (p_far_tap) else $error("far tap not clamped to border");

	property p_one_axis;
		@(posedge CORE_CLK) disable iff (!NRST)
		TAP_VALID && CUBE_EN && TAP_BILINEAR && TAP_I >= 0 && TAP_I < FACE_SIZE && TAP_J == -1
		|=> TAP_OUT_FACE != $past(TAP_FACE) && TAP_OUT_I >= 0 && TAP_OUT_J >= 0 && !TAP_CORNER;
	endproperty
	a_one_axis: assert property (p_one_axis) else $error("edge tap not moved to neighbour");

	property p_corner_same;
		@(posedge CORE_CLK) disable iff (!NRST)
		CORNER_VALID && CORNER_A == CORNER_B && CORNER_B == CORNER_C
		|=> CORNER_OUT_VALID && CORNER_OUT == $past(CORNER_A);
	endproperty
	a_corner_same: assert property (p_corner_same) else $error("corner of equal samples differs");

	property p_corner_flag;
		@(posedge CORE_CLK) disable iff (!NRST)
		TAP_VALID && CUBE_EN && TAP_BILINEAR && TAP_I == -1 && TAP_J == -1 |=> TAP_CORNER;
	endproperty
	a_corner_flag: assert property (p_corner_flag) else $error("corner tap not flagged");
endmodule
`default_nettype wire

// ===== verif/cmfs_sink_model.sv
// sink model of the texel fetch side taking face coordinates
`timescale 1ns/1ps
`default_nettype none
module cmfs_sink_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// result stream in
	input  wire logic       valid,
	input  wire logic [3:0] stall,
	output logic            ready
);
	logic [3:0] cnt;
	// one ready pulse per result, after stall cycles of back-pressure
	always_ff @(posedge clk) begin
		cnt   <= (nrst && valid && cnt != 4'hf) ? cnt + 4'h1 : 4'h0;
		ready <= nrst && valid && !ready && cnt >= stall; // pulse avoids taking two results
	end
endmodule
`default_nettype wire

// ===== verif/cmfs_face_select_test.sv
// self-checking bench for the cube map face selection stage
`timescale 1ns/1ps
`default_nettype none
module cmfs_face_select_test;
	logic               clk = 1'b0, nrst = 1'b0, cube = 1'b1, in_valid = 1'b0, tap_valid = 1'b0;
	logic               tap_bil = 1'b0, corner_valid = 1'b0;
	logic signed [15:0] dir_x = 16'h0000, dir_y = 16'h0000, dir_z = 16'h0000;
	logic [2:0]         tap_face = 3'h0, out_face, tap_out_face;
	logic signed [11:0] tap_i = 12'h000, tap_j = 12'h000, tap_out_i, tap_out_j;
	logic [11:0]        face_size = 12'h004;
	logic [1:0]         wrap_s = 2'h0, wrap_t = 2'h0;
	logic [31:0]        corner_a = 32'h0, corner_b = 32'h0, corner_c = 32'h0, corner_out;
	logic [3:0]         stall = 4'h0;
	logic [15:0]        out_s, out_t;
	logic               in_ready, out_valid, out_ready, tap_out_valid, tap_corner, tap_border, corner_out_valid;
	int                 num_errors = 0, n_tests = 0;

	always #12.5 clk = ~clk;

	cmfs_face_select dut (.CORE_CLK(clk), .NRST(nrst), .CUBE_EN(cube), .IN_VALID(in_valid), .IN_READY(in_ready),
		.DIR_X(dir_x), .DIR_Y(dir_y), .DIR_Z(dir_z), .OUT_VALID(out_valid), .OUT_READY(out_ready),
		.OUT_FACE(out_face), .OUT_S(out_s), .OUT_T(out_t), .TAP_VALID(tap_valid), .TAP_FACE(tap_face),
		.TAP_I(tap_i), .TAP_J(tap_j), .FACE_SIZE(face_size), .TAP_BILINEAR(tap_bil), .WRAP_S(wrap_s),
		.WRAP_T(wrap_t), .TAP_OUT_VALID(tap_out_valid), .TAP_OUT_FACE(tap_out_face), .TAP_OUT_I(tap_out_i),
		.TAP_OUT_J(tap_out_j), .TAP_CORNER(tap_corner), .TAP_BORDER(tap_border), .CORNER_VALID(corner_valid),
		.CORNER_A(corner_a), .CORNER_B(corner_b), .CORNER_C(corner_c), .CORNER_OUT_VALID(corner_out_valid),
		.CORNER_OUT(corner_out));

	cmfs_sink_model sink (.clk(clk), .nrst(nrst), .valid(out_valid), .stall(stall), .ready(out_ready));

	// ----------------------------------------
	// shared checking and closing
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// one direction through, sink stalls st cycles; expected s,t from face-local sc,tc,ma
	task automatic dir_case(input logic c, input int x, y, z, input logic [2:0] ef, input int sc, tc, ma, st);
		int          am;
		int          n;
		logic [15:0] es;
		logic [15:0] et;
		am = ma < 0 ? -ma : ma;
		// zero vector has no major axis: face centre, no division
		es = !c ? x[15:0] : (am == 0) ? 16'h4000 : 16'(((sc + am) * 32768) / (2 * am));
		et = !c ? y[15:0] : (am == 0) ? 16'h4000 : 16'(((tc + am) * 32768) / (2 * am));
		@(negedge clk);
		cube = c;
		stall = st[3:0];
		in_valid = 1'b1;
		dir_x = x[15:0];
		dir_y = y[15:0];
		dir_z = z[15:0];
		@(negedge clk);
		in_valid = 1'b0;
		n = 1;
		while (out_valid !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk(n, (c && am != 0) ? 18 : 1);
		chk({out_face, out_s, out_t}, {ef, es, et});
		// result must stand and new requests stay refused while the sink stalls
		while (out_ready !== 1'b1 && n < 80) begin
			chk({out_valid, in_ready}, 2'b10);
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		chk({out_valid, in_ready}, 2'b01);
	endtask

	// one filter tap through, four-texel faces
	task automatic tap(input logic c, b, input logic [1:0] ws, wt, input logic [2:0] f, input int i, j,
		input logic [2:0] ef, input int ei, ej, input logic ec, eb);
		@(negedge clk);
		cube = c;
		tap_bil = b;
		wrap_s = ws;
		wrap_t = wt;
		tap_valid = 1'b1;
		tap_face = f;
		tap_i = i[11:0];
		tap_j = j[11:0];
		@(negedge clk);
		tap_valid = 1'b0;
		chk(tap_out_valid, 1'b1);
		chk({tap_out_face, tap_out_i, tap_out_j, tap_corner, tap_border}, {ef, ei[11:0], ej[11:0], ec, eb});
	endtask

	task automatic corner(input logic [31:0] a, b, c, e);
		@(negedge clk);
		corner_valid = 1'b1;
		corner_a = a;
		corner_b = b;
		corner_c = c;
		@(negedge clk);
		corner_valid = 1'b0;
		chk({corner_out_valid, corner_out}, {1'b1, e});
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		dir_case(1, 'h1000, 'h0800, -'h0400, 3'h0, 'h400, -'h800, 'h1000, 5);
		dir_case(1, -'h1000, 'h0800, 'h0400, 3'h1, 'h400, -'h800, -'h1000, 0);
		dir_case(1, 'h0400, 'h1000, 'h0800, 3'h2, 'h400, 'h800, 'h1000, 2);
		dir_case(1, 'h0400, -'h1000, 'h0800, 3'h3, 'h400, -'h800, -'h1000, 0);
		dir_case(1, 'h0400, 'h0800, 'h1000, 3'h4, 'h400, -'h800, 'h1000, 0);
		dir_case(1, 'h0400, 'h0800, -'h1000, 3'h5, -'h400, -'h800, -'h1000, 0);
		dir_case(1, 'h3000, 'h1000, 'h0000, 3'h0, 'h0, -'h1000, 'h3000, 0);
		dir_case(1, 'h1000, -'h1000, 'h1000, 3'h0, -'h1000, 'h1000, 'h1000, 0);
		dir_case(1, -'h0800, 'h0800, 'h0800, 3'h1, 'h800, -'h800, -'h800, 0);
		dir_case(1, 'h0800, 'h0800, 'h0800, 3'h0, -'h800, -'h800, 'h800, 0);
		dir_case(1, 0, 0, 0, 3'h0, 0, 0, 0, 0);
		dir_case(1, 0, 'h1000, 0, 3'h2, 0, 0, 'h1000, 0);
		dir_case(1, -'h4000, 0, 'h4000, 3'h1, 'h4000, 0, -'h4000, 0);
		dir_case(0, 'h1234, 'h5678, 'h0100, 3'h0, 0, 0, 1, 0);
		tap(1, 0, 2'h2, 2'h3, 3'h0, -1, 4, 3'h0, 0, 3, 0, 0);
		tap(1, 1, 2'h0, 2'h0, 3'h2, 1, 2, 3'h2, 1, 2, 0, 0);
		tap(1, 1, 2'h2, 2'h2, 3'h0, -1, 1, 3'h4, 3, 1, 0, 0);
		tap(1, 1, 2'h0, 2'h0, 3'h0, -3, 1, 3'h4, 3, 1, 0, 0);
		tap(1, 1, 2'h0, 2'h0, 3'h0, -2, 5, 3'h0, -1, 4, 1, 0);
		tap(0, 1, 2'h1, 2'h0, 3'h0, -3, 9, 3'h0, -1, 3, 0, 1);
		tap(0, 0, 2'h0, 2'h0, 3'h0, 7, -2, 3'h0, 3, 0, 0, 0);
		tap(0, 1, 2'h2, 2'h3, 3'h3, -3, 9, 3'h3, -3, 9, 0, 1);
		tap(1, 1, 2'h0, 2'h0, 3'h1, 1, -1, 3'h2, 0, 1, 0, 0);
		tap(1, 1, 2'h0, 2'h0, 3'h0, -1, -1, 3'h0, -1, -1, 1, 0);
		corner(32'h0310ff00, 32'h0620ff00, 32'h0931ff00, 32'h0620ff00);
		corner(32'ha5c37e19, 32'ha5c37e19, 32'ha5c37e19, 32'ha5c37e19);
		report_and_stop();
	end

	// hang guard, far beyond the few hundred cycles the sequence needs
	initial begin
		#100000;
		num_errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
